// ### design/time_source_failover.sv
// Time input source selection with priority failover, lock reporting and shared trigger/pulse pin
//
// Operation
// R1: Primary failed: use first backup as active source.
// R2: Primary and first backup failed: use second backup.
// R3: All failed or no backups: use internal free-running source.
// R4: Inactive backups still poll, but never update local time.
// R5: Line-busy indicator lit while modem source calls out.
// R6: After failover without immediate call-out, update at next scheduled call-out.
// R7: Active source readable by software.
// R8: Time lock set while active source delivers valid time.
// R9: Frequency lock: none, data unlocked, data locked.
// R10: Further states for pulse, video lock and reference lock.
// R11: Combined reference and pulse state for one receiver type.
// R12: Pin set to pulse: lock to shared pin pulses.
// R13: Pin set to trigger and armed: ground applies staged time.
// R14: Pin synchronised; only the edge into ground acts, once.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module time_source_failover
#(
	parameter int PULSE_TIMEOUT = failover_pkg::PULSE_TIMEOUT_CYC
)
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  src_ok,
	input  wire logic [7:0]  src_time_valid,
	input  wire logic [7:0]  src_update,
	input  wire logic [7:0]  src_calling,
	input  wire logic        loop_locked,
	input  wire logic        video_lock_in,
	input  wire logic        ref_lock_in,
	input  wire logic        shared_pin,
	output logic             local_time_load,
	output logic [2:0]       local_time_src,
	output logic             staged_time_apply,
	output logic             line_busy,
	output logic [2:0]       active_source,
	output logic             time_locked,
	output logic [2:0]       freq_lock_state,
	output logic             irq
);

	// ***********************************************************
	// Register bus
	// ***********************************************************
	logic [31:0] src_cfg_reg;
	logic [2:0]  ctrl_reg;
	logic [2:0]  irq_stat_reg;
	logic [2:0]  irq_stat_next;
	logic [2:0]  irq_mask_reg;
	logic [31:0] rd_data;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign addr_ok = (paddr == failover_pkg::OFS_SRC_CFG) | (paddr == failover_pkg::OFS_CTRL)
		| (paddr == failover_pkg::OFS_STATUS) | (paddr == failover_pkg::OFS_IRQ_STAT)
		| (paddr == failover_pkg::OFS_IRQ_MASK);
	assign pslverr = psel & penable & ~addr_ok;

	function automatic logic [2:0] cfg_src(input logic [31:0] cfg, input int pos);
		cfg_src = cfg[pos +: 3];
	endfunction

	// Source per slot
	logic [2:0] prim_src;
	logic [2:0] back1_src;
	logic [2:0] back2_src;
	assign prim_src  = cfg_src(src_cfg_reg, failover_pkg::SRC_PRIMARY_POS);
	assign back1_src = cfg_src(src_cfg_reg, failover_pkg::SRC_BACKUP1_POS);
	assign back2_src = cfg_src(src_cfg_reg, failover_pkg::SRC_BACKUP2_POS);

	logic pin_as_pulse;
	logic trig_armed;
	logic ref_pulse_rx;
	assign pin_as_pulse = ctrl_reg[failover_pkg::CTRL_PIN_FUNC_POS];
	assign trig_armed   = ctrl_reg[failover_pkg::CTRL_ARM_POS];
	assign ref_pulse_rx = ctrl_reg[failover_pkg::CTRL_REF_RX_POS];

	// ***********************************************************
	// Failover selection
	// ***********************************************************
	// A source is usable when configured and healthy
	function automatic logic usable(input logic [2:0] s, input logic [7:0] ok);
		usable = (s != 3'h0) && ok[s];
	endfunction

	logic prim_ok;
	logic back1_ok;
	logic back2_ok;
	assign prim_ok  = usable(prim_src, src_ok);
	assign back1_ok = usable(back1_src, src_ok);
	assign back2_ok = usable(back2_src, src_ok);

	failover_pkg::slot_t slot_reg;
	failover_pkg::slot_t slot_next;

	// Priority order re-evaluated each cycle, so a recovered primary wins back
	assign slot_next = prim_ok ? failover_pkg::SLOT_PRIMARY
		: back1_ok ? failover_pkg::SLOT_BACKUP1 // R1
		: back2_ok ? failover_pkg::SLOT_BACKUP2 // R2
		: failover_pkg::SLOT_INTERNAL; // R3

	logic [2:0] sel_src;
	always_comb
	begin
		unique case (slot_reg)
			failover_pkg::SLOT_PRIMARY:  sel_src = prim_src;
			failover_pkg::SLOT_BACKUP1:  sel_src = back1_src;
			failover_pkg::SLOT_BACKUP2:  sel_src = back2_src;
			failover_pkg::SLOT_INTERNAL: sel_src = 3'h0;
		endcase
	end

	logic [2:0] active_reg;
	logic       slot_chg;
	assign slot_chg = slot_next != slot_reg;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			slot_reg   <= failover_pkg::SLOT_INTERNAL;
			active_reg <= 3'h0;
		end
		else
		begin
			slot_reg   <= slot_next;
			active_reg <= sel_src;
		end
	end

	assign active_source = active_reg; // R7

	// ***********************************************************
	// Local time updates
	// ***********************************************************
	// Only the active source's update loads time; others keep polling unseen.
	// No update is forced at a switch: the next call-out of the new source does it.
	logic       load_reg;
	logic [2:0] load_src_reg;
	logic       active_upd;
	assign active_upd = (active_reg != 3'h0) && src_update[active_reg] && src_time_valid[active_reg]
		&& !slot_chg; // R4 R6

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			load_reg     <= 1'b0;
			load_src_reg <= 3'h0;
		end
		else
		begin
			load_reg     <= active_upd; // R4
			load_src_reg <= active_reg;
		end
	end

	assign local_time_load = load_reg;
	assign local_time_src  = load_src_reg;

	// Modem busy indicator follows the modem's call-out whatever its slot
	logic busy_reg;
	logic modem_cfg;
	assign modem_cfg = (prim_src == failover_pkg::SRC_MODEM) | (back1_src == failover_pkg::SRC_MODEM)
		| (back2_src == failover_pkg::SRC_MODEM);
	always_ff @(posedge clk)
	begin
		if (!rstn)
			busy_reg <= 1'b0;
		else
			busy_reg <= modem_cfg & src_calling[failover_pkg::SRC_MODEM]; // R5
	end
	assign line_busy = busy_reg;

	// ***********************************************************
	// Shared pin
	// ***********************************************************
	logic pin_fall;
	pin_edge_sync u_pin
	(
		.clk      (clk),
		.rstn     (rstn),
		.pin_in   (shared_pin),
		.pin_fall (pin_fall)
	);

	logic apply_reg;
	always_ff @(posedge clk)
	begin
		if (!rstn)
			apply_reg <= 1'b0;
		else
			apply_reg <= pin_fall & ~pin_as_pulse & trig_armed; // R13 R14
	end
	assign staged_time_apply = apply_reg;

	// Pulse presence: seen within the timeout after the last edge
	localparam int CNT_W = $clog2(PULSE_TIMEOUT + 1);
	logic [CNT_W-1:0] pulse_cnt_reg;
	logic             pulse_seen_reg;
	always_ff @(posedge clk)
	begin
		if (!rstn || !pin_as_pulse)
		begin
			pulse_cnt_reg  <= '0;
			pulse_seen_reg <= 1'b0;
		end
		else if (pin_fall)
		begin
			pulse_cnt_reg  <= '0; // R12
			pulse_seen_reg <= 1'b1;
		end
		else if (pulse_cnt_reg == CNT_W'(PULSE_TIMEOUT))
			pulse_seen_reg <= 1'b0;
		else
			pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
	end

	// ***********************************************************
	// Lock status
	// ***********************************************************
	logic       tlock_reg;
	logic [2:0] flock_reg;
	logic [2:0] flock_next;
	assign flock_next = (active_reg == 3'h0) ? failover_pkg::FL_NONE // R9
		: (ref_lock_in && pulse_seen_reg && ref_pulse_rx) ? failover_pkg::FL_REF_PULSE // R11
		: ref_lock_in ? failover_pkg::FL_REF // R10
		: video_lock_in ? failover_pkg::FL_VIDEO // R10
		: pulse_seen_reg ? failover_pkg::FL_PULSE // R10 R12
		: loop_locked ? failover_pkg::FL_DATA_LOCKED // R9
		: failover_pkg::FL_DATA_UNLOCKED; // R9

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			tlock_reg <= 1'b0;
			flock_reg <= failover_pkg::FL_NONE;
		end
		else
		begin
			tlock_reg <= (active_reg != 3'h0) && src_time_valid[active_reg]; // R8
			flock_reg <= flock_next;
		end
	end
	assign time_locked     = tlock_reg;
	assign freq_lock_state = flock_reg;

	// ***********************************************************
	// Registers and interrupts
	// ***********************************************************
	logic [2:0] irq_evt;
	assign irq_evt = {tlock_reg != ((active_reg != 3'h0) && src_time_valid[active_reg]), apply_reg,
		slot_chg && slot_next != failover_pkg::SLOT_PRIMARY};

	logic rd_stat;
	assign rd_stat = rd_en && paddr == failover_pkg::OFS_IRQ_STAT;
	// Set wins over the read-clear
	assign irq_stat_next = (rd_stat ? 3'h0 : irq_stat_reg) | irq_evt;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			src_cfg_reg  <= failover_pkg::SRC_CFG_RST;
			ctrl_reg     <= failover_pkg::CTRL_RST;
			irq_mask_reg <= failover_pkg::IRQ_MASK_RST;
			irq_stat_reg <= 3'h0;
		end
		else
		begin
			if (wr_en && paddr == failover_pkg::OFS_SRC_CFG)
				src_cfg_reg <= pwdata & 32'h0000_0777;
			if (wr_en && paddr == failover_pkg::OFS_CTRL)
				ctrl_reg <= pwdata[2:0];
			if (wr_en && paddr == failover_pkg::OFS_IRQ_MASK)
				irq_mask_reg <= pwdata[2:0];
			irq_stat_reg <= irq_stat_next;
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	always_comb
	begin
		rd_data = 32'h0000_0000;
		unique case (paddr)
			failover_pkg::OFS_SRC_CFG:  rd_data = src_cfg_reg;
			failover_pkg::OFS_CTRL:     rd_data = {29'h0, ctrl_reg};
			failover_pkg::OFS_STATUS:   rd_data = {20'h0, busy_reg, flock_reg, 1'b0, tlock_reg, slot_reg,
				1'b0, active_reg};
			failover_pkg::OFS_IRQ_STAT: rd_data = {29'h0, irq_stat_reg};
			failover_pkg::OFS_IRQ_MASK: rd_data = {29'h0, irq_mask_reg};
			default:                    rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_data;
	end

	// ***********************************************************
	// Checks
	// ***********************************************************
	a_backup1_taken: assert property (@(posedge clk) disable iff (!rstn)
		(!prim_ok && back1_ok) |=> slot_reg == failover_pkg::SLOT_BACKUP1) // R1
		else $error("first backup not taken");
	a_backup2_taken: assert property (@(posedge clk) disable iff (!rstn)
		(!prim_ok && !back1_ok && back2_ok) |=> slot_reg == failover_pkg::SLOT_BACKUP2) // R2
		else $error("second backup not taken");
	a_internal_fall: assert property (@(posedge clk) disable iff (!rstn)
		(!prim_ok && !back1_ok && !back2_ok) |=> ##1 active_source == 3'h0) // R3
		else $error("internal fallback missed");
	a_inactive_no_load: assert property (@(posedge clk) disable iff (!rstn)
		local_time_load |-> $past(src_update[active_source])) // R4
		else $error("load from inactive source");
	a_busy_follows: assert property (@(posedge clk) disable iff (!rstn)
		(modem_cfg && src_calling[3]) |=> line_busy) // R5
		else $error("line busy not lit");
	a_switch_no_load: assert property (@(posedge clk) disable iff (!rstn)
		slot_chg |=> !local_time_load) // R6
		else $error("load forced at switch");
	a_time_lock: assert property (@(posedge clk) disable iff (!rstn)
		(active_reg != 3'h0 && src_time_valid[active_reg]) |=> time_locked) // R8
		else $error("time lock missing");
	a_free_none: assert property (@(posedge clk) disable iff (!rstn)
		active_reg == 3'h0 |=> freq_lock_state == failover_pkg::FL_NONE) // R9
		else $error("free-run not none");
	a_trig_apply: assert property (@(posedge clk) disable iff (!rstn)
		(pin_fall && !pin_as_pulse && trig_armed) |=> staged_time_apply ##1 !staged_time_apply) // R13
		else $error("trigger not applied once");
	a_pulse_ignored: assert property (@(posedge clk) disable iff (!rstn)
		pin_as_pulse |=> !staged_time_apply) // R12
		else $error("pulse treated as trigger");

	c_failover:  cover property (@(posedge clk) disable iff (!rstn) slot_reg == failover_pkg::SLOT_BACKUP2);
	c_trigger:   cover property (@(posedge clk) disable iff (!rstn) staged_time_apply);
	c_ref_pulse: cover property (@(posedge clk) disable iff (!rstn) freq_lock_state == failover_pkg::FL_REF_PULSE);

endmodule

// ### shared/failover_pkg.sv
// Package: register map, field layouts, enumerations and timing constants for the source failover block
package failover_pkg;

	// Source codes; zero means not configured
	typedef enum logic [2:0]
	{
		SRC_NONE  = 3'h0,
		SRC_GPS   = 3'h1,
		SRC_RADIO = 3'h2,
		SRC_MODEM = 3'h3,
		SRC_SER   = 3'h4,
		SRC_NET   = 3'h5,
		SRC_VIDEO = 3'h6,
		SRC_REF   = 3'h7
	} src_code_t;

	// Active slot, Gray along primary -> backup 1 -> backup 2 -> internal
	typedef enum logic [1:0]
	{
		SLOT_PRIMARY = 2'h0,
		SLOT_BACKUP1 = 2'h1,
		SLOT_BACKUP2 = 2'h3,
		SLOT_INTERNAL = 2'h2
	} slot_t;

	// Frequency lock codes
	typedef enum logic [2:0]
	{
		FL_NONE          = 3'h0,
		FL_DATA_UNLOCKED = 3'h1,
		FL_DATA_LOCKED   = 3'h2,
		FL_PULSE         = 3'h3,
		FL_VIDEO         = 3'h4,
		FL_REF           = 3'h5,
		FL_REF_PULSE     = 3'h6
	} freq_lock_t;

	// Register offsets
	localparam logic [7:0] OFS_SRC_CFG   = 8'h00;
	localparam logic [7:0] OFS_CTRL      = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

	// Source config fields
	localparam int SRC_PRIMARY_POS = 0;
	localparam int SRC_BACKUP1_POS = 4;
	localparam int SRC_BACKUP2_POS = 8;
	localparam int SRC_W           = 3;

	// Control fields
	localparam int CTRL_PIN_FUNC_POS = 0;
	localparam int CTRL_ARM_POS      = 1;
	localparam int CTRL_REF_RX_POS   = 2;

	// Status fields
	localparam int ST_ACTIVE_POS   = 0;
	localparam int ST_SLOT_POS     = 4;
	localparam int ST_TLOCK_POS    = 6;
	localparam int ST_FLOCK_POS    = 8;
	localparam int ST_BUSY_POS     = 11;

	// Interrupt events
	localparam int IRQ_W          = 3;
	localparam int IRQ_FAILOVER   = 0;
	localparam int IRQ_TRIGGER    = 1;
	localparam int IRQ_LOCK_CHG   = 2;

	// Reset values
	localparam logic [31:0] SRC_CFG_RST  = 32'h0000_0000;
	localparam logic [2:0]  CTRL_RST     = 3'h0;
	localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

	// Pulse presence timeout: a pulse per second must come within this time
	localparam int PULSE_TIMEOUT_MS = 1500;
	localparam int CLK_HZ           = 20000000;
	localparam int PULSE_TIMEOUT_CYC = (PULSE_TIMEOUT_MS / 1000) * CLK_HZ + ((PULSE_TIMEOUT_MS % 1000) * (CLK_HZ / 1000));

endpackage

// ### design/pin_edge_sync.sv
// Synchroniser and falling-edge detector for the shared trigger/pulse pin
`timescale 1ns/1ps
module pin_edge_sync
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic pin_in,
	output logic      pin_fall
);

	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;

	// Pin idles high; grounding it is the active level
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			stage1_reg <= 1'b1;
			stage2_reg <= 1'b1;
			stage3_reg <= 1'b1;
		end
		else
		begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// Edge taken from stages two and three only
	assign pin_fall = stage3_reg & ~stage2_reg; // R14

	a_fall_one_cycle: assert property (@(posedge clk) disable iff (!rstn) pin_fall |=> !pin_fall) // R14
		else $error("pin edge longer than one cycle");

endmodule

// ### testbench/time_refs.sv
// Model of the external time references and the shared trigger/pulse pin
`timescale 1ns/1ps
//**********************************************
// External references
//**********************************************
module time_refs
(
	input  wire logic       clk,
	input  wire logic [7:0] health,
	input  wire logic [7:0] calling,
	input  wire logic [7:0] upd,
	input  wire logic       pps_en,
	input  wire logic       ground,
	output logic      [7:0] src_ok,
	output logic      [7:0] src_time_valid,
	output logic      [7:0] src_update,
	output logic      [7:0] src_calling,
	output logic            shared_pin
);
	logic [4:0] pps_cnt = 5'h00;
	// A failed reference sends nothing at all
	assign src_ok         = health;
	assign src_time_valid = health;
	assign src_update     = upd & health;
	assign src_calling    = calling & health;
	// Pin idles high; grounding it is the trigger
	assign shared_pin = ~(ground | (pps_en && pps_cnt < 5'h02));
	// Pulse every 20 cycles, well inside the shortened timeout
	always @(posedge clk)
		pps_cnt <= (pps_cnt == 5'h13) ? 5'h00 : pps_cnt + 5'h01;
endmodule

// ### testbench/tb.sv
// Self-checking bench for the time source failover block
`timescale 1ns/1ps
//**********************************************
// Bench top
//**********************************************
module tb;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  health = 8'h00;
	logic [7:0]  calling = 8'h00;
	logic [7:0]  upd = 8'h00;
	logic        pps_en = 1'b0;
	logic        ground = 1'b0;
	logic        loop_locked = 1'b0;
	logic        video_lock_in = 1'b0;
	logic        ref_lock_in = 1'b0;
	logic [7:0]  src_ok;
	logic [7:0]  src_time_valid;
	logic [7:0]  src_update;
	logic [7:0]  src_calling;
	logic        shared_pin;
	logic        local_time_load;
	logic [2:0]  local_time_src;
	logic        staged_time_apply;
	logic        line_busy;
	logic [2:0]  active_source;
	logic        time_locked;
	logic [2:0]  freq_lock_state;
	logic        irq;
	int          failures = 0;
	int          num_checks = 0;
	int          loads = 0;
	int          applies = 0;
	// Row: cfg[39:28] health[27:20] ctrl[19:16] {loop,video,ref,pps}[15:12] active[11:8] flock[7:4] tlock[3:0]
	logic [39:0] rows [9] = '{40'h5312A00111, 40'h5312800311, 40'h5312008521, 40'h5310000000,
		40'h0012800000, 40'h0064004641, 40'h0078002751, 40'h0010211131, 40'h0010253161};
	logic [2:0]  pin_ctrl [3] = '{3'h2, 3'h0, 3'h3};
	logic [1:0]  pin_exp [3] = '{2'h1, 2'h0, 2'h0};

	always #25 clk = ~clk;

	time_refs i_refs (.clk(clk), .health(health), .calling(calling), .upd(upd), .pps_en(pps_en),
		.ground(ground), .src_ok(src_ok), .src_time_valid(src_time_valid), .src_update(src_update),
		.src_calling(src_calling), .shared_pin(shared_pin));

	// Short pulse timeout keeps the run small
	time_source_failover #(.PULSE_TIMEOUT(50)) i_dut (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_ok(src_ok), .src_time_valid(src_time_valid),
		.src_update(src_update), .src_calling(src_calling), .loop_locked(loop_locked),
		.video_lock_in(video_lock_in), .ref_lock_in(ref_lock_in), .shared_pin(shared_pin),
		.local_time_load(local_time_load), .local_time_src(local_time_src),
		.staged_time_apply(staged_time_apply), .line_busy(line_busy), .active_source(active_source),
		.time_locked(time_locked), .freq_lock_state(freq_lock_state), .irq(irq));

	// Pulses counted mid-cycle, clear of the launching edge
	always @(negedge clk)
	begin
		if (local_time_load === 1'b1)
			loads++;
		if (staged_time_apply === 1'b1)
			applies++;
	end

	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse_upd(input logic [7:0] v);
		@(posedge clk);
		upd <= v;
		@(posedge clk);
		upd <= 8'h00;
		tick(3);
	endtask

	initial
	begin
		#250000;
		failures++;
		stop_test();
	end

	initial
	begin
		logic [31:0] q;
		logic        e;
		logic [39:0] r;
		int          base;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		tick(1);
		check(32'(active_source), 32'h0);
		check(32'(freq_lock_state), 32'(failover_pkg::FL_NONE));
		check(32'(irq), 32'h0);
		check(32'(pready), 32'h1);
		check(32'(pslverr), 32'h0);
		apb(1'b0, failover_pkg::OFS_SRC_CFG, 32'h0, q, e);
		check(q, failover_pkg::SRC_CFG_RST);
		apb(1'b0, failover_pkg::OFS_IRQ_MASK, 32'h0, q, e);
		check(q, 32'(failover_pkg::IRQ_MASK_RST));
		apb(1'b0, 8'h40, 32'h0, q, e);
		check({q[30:0], e}, 32'h1);
		for (int i = 0; i < 9; i++)
		begin
			r = rows[i];
			apb(1'b1, failover_pkg::OFS_SRC_CFG, {20'h0, r[39:28]}, q, e);
			apb(1'b1, failover_pkg::OFS_CTRL, {28'h0, r[19:16]}, q, e);
			health <= r[27:20];
			{loop_locked, video_lock_in, ref_lock_in, pps_en} <= r[15:12];
			tick(45);
			check(32'(active_source), {28'h0, r[11:8]});
			check(32'(freq_lock_state), {28'h0, r[7:4]});
			check(32'(time_locked), {28'h0, r[3:0]});
			apb(1'b0, failover_pkg::OFS_STATUS, 32'h0, q, e);
			check(32'(q[2:0]), {28'h0, r[11:8]});
		end
		// Inactive backups report but must not load local time
		apb(1'b1, failover_pkg::OFS_SRC_CFG, 32'h0000_0531, q, e);
		apb(1'b1, failover_pkg::OFS_CTRL, 32'h0, q, e);
		apb(1'b1, failover_pkg::OFS_IRQ_MASK, 32'h1, q, e);
		health <= 8'h2A;
		{loop_locked, video_lock_in, ref_lock_in, pps_en} <= 4'h0;
		tick(5);
		// Earlier rows left sticky events behind
		apb(1'b0, failover_pkg::OFS_IRQ_STAT, 32'h0, q, e);
		tick(1);
		check(32'(irq), 32'h0);
		base = loads;
		pulse_upd(8'h20);
		check(32'(loads - base), 32'h0);
		pulse_upd(8'h02);
		check(32'(loads - base), 32'h1);
		check(32'(local_time_src), 32'(failover_pkg::SRC_GPS));
		@(posedge clk);
		health <= 8'h28;
		tick(5);
		check(32'(irq), 32'h1);
		pulse_upd(8'h08);
		check(32'(loads - base), 32'h2);
		check(32'(local_time_src), 32'(failover_pkg::SRC_MODEM));
		@(posedge clk);
		calling <= 8'h08;
		tick(3);
		check(32'(line_busy), 32'h1);
		@(posedge clk);
		calling <= 8'h00;
		tick(3);
		check(32'(line_busy), 32'h0);
		apb(1'b0, failover_pkg::OFS_IRQ_STAT, 32'h0, q, e);
		check(32'(q[0]), 32'h1);
		tick(1);
		check(32'(irq), 32'h0);
		apb(1'b1, failover_pkg::OFS_IRQ_MASK, 32'h0, q, e);
		health <= 8'h2A;
		tick(5);
		@(posedge clk);
		health <= 8'h28;
		tick(5);
		check(32'(irq), 32'h0);
		// Pin held low well past one edge: at most one apply
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, failover_pkg::OFS_CTRL, 32'(pin_ctrl[i]), q, e);
			base = applies;
			@(posedge clk);
			ground <= 1'b1;
			tick(10);
			@(posedge clk);
			ground <= 1'b0;
			tick(6);
			check(32'(applies - base), 32'(pin_exp[i]));
		end
		stop_test();
	end
endmodule
